/* File: common/pia_pkg.sv */
// Purpose: shared constants for the indirect access window and status extension words
// Assumes: 16-bit management words and 5-bit register addresses
// Notes: offsets are main-space register numbers
package pia_pkg;

  // ==========================================================
  // register offsets
  localparam logic [4:0] OFF_ACCESS_CTRL = 5'h0D;
  localparam logic [4:0] OFF_ADDR_DATA = 5'h0E;
  localparam logic [4:0] OFF_GIG_CAP = 5'h0F;
  localparam logic [4:0] OFF_FAST_STATUS = 5'h10;
  localparam logic [4:0] OFF_GIG_STATUS = 5'h11;

  // ==========================================================
  // access control word fields
  localparam int FUNC_HI = 15;
  localparam int FUNC_LO = 14;
  localparam int DEVCODE_HI = 4;
  localparam int DEVCODE_LO = 0;
  localparam logic [1:0] FUNC_ADDRESS = 2'h0;
  localparam logic [1:0] FUNC_DATA_FIXED = 2'h1;
  localparam logic [1:0] FUNC_DATA_INC_RW = 2'h2;
  localparam logic [1:0] FUNC_DATA_INC_WR = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [15:0] ACCESS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] GIG_CAP_VALUE = 16'h3000;

  // ==========================================================
  // status word bit positions (bits 15 to 8 shared by both status words, bits 7 to 5 gigabit only)
  localparam int ST_SCRAM_LOCK = 15;
  localparam int ST_LOCK_ERR = 14;
  localparam int ST_DISCONNECT = 13;
  localparam int ST_LINK_UP = 12;
  localparam int ST_RX_ERR = 11;
  localparam int ST_TX_ERR = 10;
  localparam int ST_START_DELIM = 9;
  localparam int ST_END_DELIM = 8;
  localparam int ST_CARRIER_EXT = 7;
  localparam int ST_LEGACY_PARTNER = 6;
  localparam int ST_CROSSOVER = 5;

  // self-clearing bits of each status word
  localparam logic [15:0] FAST_STICKY_MASK = 16'h6F00;
  localparam logic [15:0] GIG_STICKY_MASK = 16'h6F80;

endpackage

/* File: rtl/pia_mmd_mem.sv */
// Purpose: storage for managed sub-device registers behind the indirect window
// Assumes: one write port, one read port, single clock
// Notes: read data comes out of a register one cycle after the index
`timescale 1ns/1ps

module pia_sub_mem #(
  parameter int WIDTH = 16,
  parameter int INDEX_BITS = 6
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic writeEnable,
  input wire logic [INDEX_BITS-1:0] writeIndex,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [INDEX_BITS-1:0] readIndex,
  output logic [WIDTH-1:0] readData
);

  logic [WIDTH-1:0] store [0:(1<<INDEX_BITS)-1];

  initial
  begin
    if (WIDTH < 1 || INDEX_BITS < 1 || INDEX_BITS > 12)
    begin
      $error("pia_sub_mem: unsupported geometry");
    end
  end

  always_ff @(posedge clock)
  begin
    if (writeEnable)
    begin
      store[writeIndex] <= writeData;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readData <= '0;
    end
    else
    begin
      readData <= store[readIndex];
    end
  end

endmodule

/* File: rtl/pia_regs.sv */
// Purpose: indirect managed sub-device window plus three status extension words
// Assumes: register strobes and status inputs are synchronous to clock
// Notes: every read takes two cycles, a write one; requests during the second read cycle are ignored
`timescale 1ns/1ps

// Functional notes
// [R1] function field picks address or data behaviour
// [R2] low five control bits select target device; only the low DEV_BITS of them are decoded
// [R3] address mode write loads sub-device address
// [R4] data mode reads and writes addressed register
// [R5] capability word reads fixed copper-gigabit flags
// [R6] fast status shows live lock and link
// [R7] fast lock error sets, clears on read
// [R8] fast disconnect sets, clears on read
// [R9] fast receive, transmit errors clear on read
// [R10] fast delimiter errors clear on read
// [R11] gigabit status shows live lock and link
// [R12] gigabit lock error sets, clears on read
// [R13] gigabit disconnect sets, clears on read
// [R14] gigabit receive, transmit errors clear on read
// [R15] gigabit delimiter errors clear on read
// [R16] carrier extension error clears on read
// [R17] legacy partner flag shown in bit six
// [R18] crossover error in bit five, rest reserved
// [R19] controller sets address then data mode
// [R20] sticky bits hold until their word is read
module pia_regs
  import pia_pkg::*;
#(
  parameter int DEV_BITS = 2,
  parameter int ADDR_BITS = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWriteData,
  output logic [15:0] regReadData,
  output logic regReadValid,
  input wire logic fastScramLock,
  input wire logic fastLinkUp,
  input wire logic fastLockErr,
  input wire logic fastDisconnect,
  input wire logic fastRxErr,
  input wire logic fastTxErr,
  input wire logic fastStartDelimErr,
  input wire logic fastEndDelimErr,
  input wire logic gigScramLock,
  input wire logic gigLinkUp,
  input wire logic gigLockErr,
  input wire logic gigDisconnect,
  input wire logic gigRxErr,
  input wire logic gigTxErr,
  input wire logic gigStartDelimErr,
  input wire logic gigEndDelimErr,
  input wire logic gigCarrierExtErr,
  input wire logic legacyPartner,
  input wire logic crossoverErr
);

  import pia_pkg::*;

  localparam int INDEX_BITS = DEV_BITS + ADDR_BITS;

  initial
  begin
    if (DEV_BITS < 1 || DEV_BITS > 5 || ADDR_BITS < 1 || ADDR_BITS > 16 || INDEX_BITS > 12)
    begin
      $error("pia_regs: unsupported window geometry");
    end
  end

  // ==========================================================
  // request acceptance
  logic readPend;
  logic [4:0] readAddrQ;
  logic takeWrite;
  logic takeRead;
  logic [15:0] accessCtrl;
  logic [15:0] subAddr;
  logic [1:0] funcMode;
  logic dataMode;
  logic subWrite;
  logic subRead;
  logic captureRead;

  assign takeWrite = regWrite && !readPend;
  assign takeRead = regRead && !regWrite && !readPend;
  assign captureRead = readPend;
  assign funcMode = accessCtrl[FUNC_HI:FUNC_LO];
  assign dataMode = (funcMode != FUNC_ADDRESS);
  assign subWrite = takeWrite && (regAddr == OFF_ADDR_DATA) && dataMode;
  assign subRead = takeRead && (regAddr == OFF_ADDR_DATA) && dataMode;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readPend <= 1'b0;
      readAddrQ <= 5'h00;
    end
    else
    begin
      readPend <= takeRead;
      if (takeRead)
      begin
        readAddrQ <= regAddr;
      end
    end
  end

  // ==========================================================
  // indirect access control word
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accessCtrl <= ACCESS_CTRL_RESET;
    end
    else if (takeWrite && regAddr == OFF_ACCESS_CTRL)
    begin
      accessCtrl <= regWriteData;
    end
  end

  // ==========================================================
  // sub-device address with post increment
  logic incNow;

  always_comb
  begin
    incNow = 1'b0;
    // [R1] increment policy per function
    case (funcMode)
      FUNC_DATA_INC_RW: incNow = subWrite || subRead;
      FUNC_DATA_INC_WR: incNow = subWrite;
      default: incNow = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      subAddr <= ADDR_RESET;
    end
    // [R3] address mode load
    else if (takeWrite && regAddr == OFF_ADDR_DATA && !dataMode)
    begin
      subAddr <= regWriteData;
    end
    else if (incNow)
    begin
      subAddr <= subAddr + 16'h0001;
    end
  end

  // ==========================================================
  // sub-device register storage
  logic [INDEX_BITS-1:0] subIndex;
  logic [15:0] subReadData;

  // [R2] device code selects the register set
  assign subIndex = {accessCtrl[DEVCODE_LO+DEV_BITS-1:DEVCODE_LO], subAddr[ADDR_BITS-1:0]};

  // [R4] data mode access to addressed register
  pia_sub_mem #(
    .WIDTH(16),
    .INDEX_BITS(INDEX_BITS)
  ) subMem (
    .clock(clock),
    .rst_b(rst_b),
    .writeEnable(subWrite),
    .writeIndex(subIndex),
    .writeData(regWriteData),
    .readIndex(subIndex),
    .readData(subReadData)
  );

  // ==========================================================
  // live status levels
  logic fastLockQ;
  logic fastLinkQ;
  logic gigLockQ;
  logic gigLinkQ;
  logic legacyQ;
  logic crossQ;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fastLockQ <= 1'b0;
      fastLinkQ <= 1'b0;
      gigLockQ <= 1'b0;
      gigLinkQ <= 1'b0;
      legacyQ <= 1'b0;
      crossQ <= 1'b0;
    end
    else
    begin
      // [R6] live fast lock and link
      fastLockQ <= fastScramLock;
      fastLinkQ <= fastLinkUp;
      // [R11] live gigabit lock and link
      gigLockQ <= gigScramLock;
      gigLinkQ <= gigLinkUp;
      // [R17] legacy partner indication
      legacyQ <= legacyPartner;
      // [R18] crossover error indication
      crossQ <= crossoverErr;
    end
  end

  // ==========================================================
  // self-clearing event bits
  logic [15:0] fastEvents;
  logic [15:0] gigEvents;
  logic [15:0] fastSticky;
  logic [15:0] gigSticky;
  logic [15:0] next_fastSticky;
  logic [15:0] next_gigSticky;
  logic fastClear;
  logic gigClear;

  always_comb
  begin
    fastEvents = 16'h0000;
    gigEvents = 16'h0000;
    // [R7] fast lock error event
    fastEvents[ST_LOCK_ERR] = fastLockErr;
    // [R8] fast disconnect event
    fastEvents[ST_DISCONNECT] = fastDisconnect;
    // [R9] fast receive and transmit errors
    fastEvents[ST_RX_ERR] = fastRxErr;
    fastEvents[ST_TX_ERR] = fastTxErr;
    // [R10] fast delimiter errors
    fastEvents[ST_START_DELIM] = fastStartDelimErr;
    fastEvents[ST_END_DELIM] = fastEndDelimErr;
    // [R12] gigabit lock error event
    gigEvents[ST_LOCK_ERR] = gigLockErr;
    // [R13] gigabit disconnect event
    gigEvents[ST_DISCONNECT] = gigDisconnect;
    // [R14] gigabit receive and transmit errors
    gigEvents[ST_RX_ERR] = gigRxErr;
    gigEvents[ST_TX_ERR] = gigTxErr;
    // [R15] gigabit delimiter errors
    gigEvents[ST_START_DELIM] = gigStartDelimErr;
    gigEvents[ST_END_DELIM] = gigEndDelimErr;
    // [R16] carrier extension error event
    gigEvents[ST_CARRIER_EXT] = gigCarrierExtErr;
  end

  assign fastClear = captureRead && (readAddrQ == OFF_FAST_STATUS);
  assign gigClear = captureRead && (readAddrQ == OFF_GIG_STATUS);

  // [R20] hold until read, new event wins over clear
  always_comb
  begin
    next_fastSticky = (fastSticky & ~(fastClear ? FAST_STICKY_MASK : 16'h0000)) | fastEvents;
    next_gigSticky = (gigSticky & ~(gigClear ? GIG_STICKY_MASK : 16'h0000)) | gigEvents;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fastSticky <= 16'h0000;
      gigSticky <= 16'h0000;
    end
    else
    begin
      fastSticky <= next_fastSticky & FAST_STICKY_MASK;
      gigSticky <= next_gigSticky & GIG_STICKY_MASK;
    end
  end

  // ==========================================================
  // read data assembly
  logic [15:0] fastWord;
  logic [15:0] gigWord;
  logic [15:0] next_readData;

  always_comb
  begin
    fastWord = fastSticky;
    fastWord[ST_SCRAM_LOCK] = fastLockQ;
    fastWord[ST_LINK_UP] = fastLinkQ;
    gigWord = gigSticky;
    gigWord[ST_SCRAM_LOCK] = gigLockQ;
    gigWord[ST_LINK_UP] = gigLinkQ;
    gigWord[ST_LEGACY_PARTNER] = legacyQ;
    gigWord[ST_CROSSOVER] = crossQ;
  end

  always_comb
  begin
    if (readAddrQ == OFF_ACCESS_CTRL)
    begin
      next_readData = accessCtrl;
    end
    else if (readAddrQ == OFF_ADDR_DATA)
    begin
      next_readData = (funcMode == FUNC_ADDRESS) ? subAddr : subReadData;
    end
    // [R5] fixed capability word
    else if (readAddrQ == OFF_GIG_CAP)
    begin
      next_readData = GIG_CAP_VALUE;
    end
    else if (readAddrQ == OFF_FAST_STATUS)
    begin
      next_readData = fastWord;
    end
    else if (readAddrQ == OFF_GIG_STATUS)
    begin
      next_readData = gigWord;
    end
    else
    begin
      next_readData = 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regReadData <= 16'h0000;
      regReadValid <= 1'b0;
    end
    else
    begin
      regReadValid <= captureRead;
      if (captureRead)
      begin
        regReadData <= next_readData;
      end
    end
  end

  // ==========================================================
  // checks
  a_cap_word: assert property (@(posedge clock) disable iff (!rst_b) // [R5]
    regReadValid && $past(readAddrQ) == OFF_GIG_CAP |-> regReadData == GIG_CAP_VALUE)
    else $error("capability word wrong");

  a_addr_load: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
    takeWrite && regAddr == OFF_ADDR_DATA && funcMode == FUNC_ADDRESS
    |=> subAddr == $past(regWriteData))
    else $error("address not loaded");

  a_inc_write: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
    subWrite && funcMode != FUNC_DATA_FIXED |=> subAddr == $past(subAddr) + 16'h0001)
    else $error("post increment missing on write");

  a_no_inc_read: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
    subRead && funcMode != FUNC_DATA_INC_RW |=> subAddr == $past(subAddr))
    else $error("address moved on read");

  a_fast_live: assert property (@(posedge clock) disable iff (!rst_b) // [R6]
    takeRead && regAddr == OFF_FAST_STATUS
    |-> ##2 regReadValid && regReadData[ST_SCRAM_LOCK] == $past(fastScramLock, 2)
    && regReadData[ST_LINK_UP] == $past(fastLinkUp, 2))
    else $error("fast live bits wrong");

  a_gig_live: assert property (@(posedge clock) disable iff (!rst_b) // [R11]
    takeRead && regAddr == OFF_GIG_STATUS
    |-> ##2 regReadData[ST_SCRAM_LOCK] == $past(gigScramLock, 2)
    && regReadData[ST_LINK_UP] == $past(gigLinkUp, 2))
    else $error("gigabit live bits wrong");

  a_fast_lockerr: assert property (@(posedge clock) disable iff (!rst_b) // [R7]
    fastLockErr |=> fastSticky[ST_LOCK_ERR] ##1 (fastSticky[ST_LOCK_ERR] || $past(fastClear)))
    else $error("fast lock error lost");

  a_fast_cleared: assert property (@(posedge clock) disable iff (!rst_b) // [R8]
    fastClear && !fastDisconnect |=> !fastSticky[ST_DISCONNECT])
    else $error("fast disconnect not cleared");

  a_fast_errs: assert property (@(posedge clock) disable iff (!rst_b) // [R9]
    fastRxErr && fastTxErr |=> fastSticky[ST_RX_ERR] && fastSticky[ST_TX_ERR])
    else $error("fast error bits not set");

  a_fast_delim: assert property (@(posedge clock) disable iff (!rst_b) // [R10]
    fastClear && !fastStartDelimErr && !fastEndDelimErr
    |=> !fastSticky[ST_START_DELIM] && !fastSticky[ST_END_DELIM])
    else $error("fast delimiter bits not cleared");

  a_gig_hold: assert property (@(posedge clock) disable iff (!rst_b) // [R20]
    gigSticky[ST_CARRIER_EXT] && !gigClear |=> gigSticky[ST_CARRIER_EXT])
    else $error("gigabit sticky bit dropped");

  a_gig_setwins: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
    gigClear && gigLockErr |=> gigSticky[ST_LOCK_ERR])
    else $error("lock error lost on clear");

endmodule

/* File: tb/pia_mgmt_host.sv */
// Purpose: management controller model that drives the register port
// Assumes: one request at a time; tasks called from the testbench
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps

module pia_mgmt_host (
  input wire logic clock,
  output logic [4:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWriteData,
  input wire logic [15:0] regReadData,
  input wire logic regReadValid
);
  initial
  begin
    regAddr = 5'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWriteData = 16'h0000;
  end

  // ==========================================================
  // write cycle
  // one word per write
  task automatic writeReg(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock);
    regAddr <= addr;
    regWriteData <= data;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr <= ~addr;
    regWriteData <= ~data;
  endtask

  // ==========================================================
  // read cycle: waits for the valid pulse, bounded
  task automatic readReg(input logic [4:0] addr, output logic [15:0] data);
    int waited;
    waited = 0;
    @(posedge clock);
    regAddr <= addr;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~addr;
    @(negedge clock);
    while (regReadValid !== 1'b1 && waited < 4)
    begin
      waited++;
      @(negedge clock);
    end
    // a missing valid pulse hands back unknowns so the compare fails
    data = (regReadValid === 1'b1) ? regReadData : 16'hXXXX;
  endtask
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the indirect window and status words
// Assumes: host model tasks for every register access
// Notes: status events are pulsed by the bench between reads, and once during a gigabit status read
`timescale 1ns/1ps

module tb;
  import pia_pkg::*;
  logic clock, rst_b, regWrite, regRead, regReadValid;
  logic [4:0] regAddr;
  logic [15:0] regWriteData, regReadData, rd;
  logic [1:0] fastLive;
  logic [5:0] fastEv, fe;
  logic [3:0] gigLive;
  logic [6:0] gigEv, ge;
  int fails, checkCount;

  pia_regs #(.DEV_BITS(2), .ADDR_BITS(4)) u_dut (
    .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData),
    .regReadValid(regReadValid), .fastScramLock(fastLive[1]), .fastLinkUp(fastLive[0]),
    .fastLockErr(fastEv[5]), .fastDisconnect(fastEv[4]), .fastRxErr(fastEv[3]),
    .fastTxErr(fastEv[2]), .fastStartDelimErr(fastEv[1]), .fastEndDelimErr(fastEv[0]),
    .gigScramLock(gigLive[3]), .gigLinkUp(gigLive[2]), .gigLockErr(gigEv[6]),
    .gigDisconnect(gigEv[5]), .gigRxErr(gigEv[4]), .gigTxErr(gigEv[3]),
    .gigStartDelimErr(gigEv[2]), .gigEndDelimErr(gigEv[1]), .gigCarrierExtErr(gigEv[0]),
    .legacyPartner(gigLive[1]), .crossoverErr(gigLive[0])
  );

  pia_mgmt_host u_host (
    .clock(clock), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ==========================================================
  // checking and verdict
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic expectReg(input string name, input logic [4:0] addr, input logic [15:0] exp);
    logic [15:0] v;
    u_host.readReg(addr, v);
    check(name, v, exp);
  endtask

  task automatic summarize();
    if (fails == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic setMode(input logic [1:0] func, input logic [4:0] dev);
    u_host.writeReg(OFF_ACCESS_CTRL, {func, 9'h000, dev});
  endtask

  task automatic wrData(input logic [15:0] d);
    u_host.writeReg(OFF_ADDR_DATA, d);
  endtask

  function automatic logic [15:0] fastWord(input logic [1:0] lv, input logic [5:0] ev);
    return {lv[1], ev[5:4], lv[0], ev[3:0], 8'h00};
  endfunction

  function automatic logic [15:0] gigWord(input logic [3:0] lv, input logic [6:0] ev);
    return {lv[3], ev[6:5], lv[2], ev[4:0], lv[1:0], 5'h00};
  endfunction

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    fails = 0;
    checkCount = 0;
    rst_b = 1'b0;
    fastLive = 2'h0;
    fastEv = 6'h00;
    gigLive = 4'h0;
    gigEv = 7'h00;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    u_host.writeReg(OFF_GIG_CAP, 16'hFFFF);
    u_host.writeReg(OFF_FAST_STATUS, 16'hFFFF);
    u_host.writeReg(OFF_GIG_STATUS, 16'hFFFF);
    expectReg("gigCap", OFF_GIG_CAP, 16'h3000);
    expectReg("fastStatus", OFF_FAST_STATUS, 16'h0000);
    expectReg("gigStatus", OFF_GIG_STATUS, 16'h0000);
    expectReg("unmapped", 5'h05, 16'h0000);
    expectReg("accessCtrl", OFF_ACCESS_CTRL, ACCESS_CTRL_RESET);
    // indirect window, address then data mode
    setMode(FUNC_ADDRESS, 5'h01);
    wrData(16'h0003);
    expectReg("addr", OFF_ADDR_DATA, 16'h0003);
    expectReg("accessCtrl", OFF_ACCESS_CTRL, 16'h0001);
    setMode(FUNC_DATA_INC_RW, 5'h01);
    wrData(16'hAAAA);
    wrData(16'hBBBB);
    setMode(FUNC_ADDRESS, 5'h01);
    expectReg("addr", OFF_ADDR_DATA, 16'h0005);
    wrData(16'h0003);
    setMode(FUNC_DATA_INC_RW, 5'h01);
    expectReg("data", OFF_ADDR_DATA, 16'hAAAA);
    expectReg("data", OFF_ADDR_DATA, 16'hBBBB);
    setMode(FUNC_ADDRESS, 5'h01);
    expectReg("addr", OFF_ADDR_DATA, 16'h0005);
    wrData(16'h0003);
    setMode(FUNC_DATA_INC_WR, 5'h01);
    expectReg("data", OFF_ADDR_DATA, 16'hAAAA);
    expectReg("data", OFF_ADDR_DATA, 16'hAAAA);
    wrData(16'hCCCC);
    u_host.writeReg(OFF_ACCESS_CTRL, 16'h5FE1);
    expectReg("accessCtrl", OFF_ACCESS_CTRL, 16'h5FE1);
    expectReg("data", OFF_ADDR_DATA, 16'hBBBB);
    wrData(16'hDDDD);
    expectReg("data", OFF_ADDR_DATA, 16'hDDDD);
    setMode(FUNC_ADDRESS, 5'h01);
    expectReg("addr", OFF_ADDR_DATA, 16'h0004);
    wrData(16'h0003);
    setMode(FUNC_DATA_FIXED, 5'h02);
    wrData(16'hEEEE);
    expectReg("data", OFF_ADDR_DATA, 16'hEEEE);
    setMode(FUNC_DATA_FIXED, 5'h01);
    expectReg("data", OFF_ADDR_DATA, 16'hCCCC);
    // status words: one event at a time, then all, with a gap of i cycles (none at first) before the read
    for (int i = 0; i < 8; i++)
    begin
      fe = (i < 6) ? 6'(1 << i) : ((i == 7) ? 6'h3F : 6'h00);
      ge = (i == 7) ? 7'h7F : 7'(1 << i);
      @(posedge clock);
      fastLive <= 2'(i);
      gigLive <= {2'(i), ~2'(i)};
      fastEv <= fe;
      gigEv <= ge;
      @(posedge clock);
      fastEv <= 6'h00;
      gigEv <= 7'h00;
      repeat (i) @(posedge clock);
      expectReg("fastStatus", OFF_FAST_STATUS, fastWord(2'(i), fe));
      expectReg("gigStatus", OFF_GIG_STATUS, gigWord({2'(i), ~2'(i)}, ge));
      expectReg("fastStatus", OFF_FAST_STATUS, fastWord(2'(i), 6'h00));
      expectReg("gigStatus", OFF_GIG_STATUS, gigWord({2'(i), ~2'(i)}, 7'h00));
    end
    // event in the clearing cycle lands in the next read
    fork
      u_host.readReg(OFF_GIG_STATUS, rd);
      begin
        repeat (2) @(posedge clock);
        gigEv <= 7'h40;
        @(posedge clock);
        gigEv <= 7'h00;
      end
    join
    check("gigStatus", rd, gigWord(4'hC, 7'h00));
    expectReg("gigStatus", OFF_GIG_STATUS, gigWord(4'hC, 7'h40));
    summarize();
  end
endmodule
